// *** include/cwd_pkg.sv ***
// package for the configuration word decoder and code-protect gate
// Function
// - configuration words live at program addresses 8007h and 8008h
// - unimplemented bits of both words read back as one
// - blank or bulk-erased words read as all ones
// - clock output enable is active low; one frees the pin for I/O
// - brown-out field: 11 on, 10 off in sleep, 01 software, 00 off
// - code protect is active low
// - reset pin select ignored with low-voltage programming; else reset or input
// - power-up timer enable is active low
// - watchdog field: 11 on, 10 off in sleep, 01 software, 00 off
// - oscillator field: 11/10/01 external clock power levels, 00 internal
// - brown-out enable never turns on the power-up timer
// - code protection clears only through bulk erase
// - low-voltage programming bit one enables low-voltage entry
// - in low-voltage programming mode the bit cannot be programmed to zero
// - low-power brown-out enable is active low
// - brown-out voltage select one picks the low trip point
// - stack-error reset enable one makes stack faults reset
// - self-write field protects none, 000-1FF, 000-3FF or 000-7FF
// - code protection blocks external writes and reads return zero
// - cpu reads always pass; cpu writes gated by settings_valid and self-write range only
package cwd_pkg;
  localparam logic [15:0] CFG1_ADDR     = 16'h8007;
  localparam logic [15:0] CFG2_ADDR     = 16'h8008;
  localparam logic [13:0] CFG_ERASED    = 14'h3FFF;
  localparam logic [13:0] CFG1_UNIMP    = 14'h3104;
  localparam logic [13:0] CFG2_UNIMP    = 14'h11FC;
  localparam int          C1_CLOCK_OUTPUT_PIN_N   = 11;
  localparam int          C1_BOREN_LO   = 9;
  localparam int          C1_CP_N       = 7;
  localparam int          C1_RSTPIN     = 6;
  localparam int          C1_POWERUP_DELAY_TIMER_N     = 5;
  localparam int          C1_WDTE_LO    = 3;
  localparam int          C1_FOSC_LO    = 0;
  localparam int          C2_LVP        = 13;
  localparam int          C2_LOW_POWER_BROWNOUT_ENABLE_N_N    = 11;
  localparam int          C2_BROWNOUT_VOLTAGE_SELECT       = 10;
  localparam int          C2_STACK_ERROR_RESET_ENABLE     = 9;
  localparam int          C2_WRT_LO     = 0;
  localparam logic [14:0] WRT_TOP_HALF  = 15'h01FF;
  localparam logic [14:0] WRT_TOP_ONE   = 15'h03FF;
  localparam logic [14:0] WRT_TOP_ALL   = 15'h07FF;
  localparam int          SAMPLE_CYC    = 2;
  typedef enum logic [1:0] {CWD_EN_OFF, CWD_EN_SW, CWD_EN_RUN, CWD_EN_ON} cwd_en_e;
  typedef enum logic [1:0] {CWD_OSC_INT, CWD_OSC_EXT_LP, CWD_OSC_EXT_MP, CWD_OSC_EXT_HP} cwd_osc_e;
endpackage : cwd_pkg

// *** rtl/cwd_config_decode.sv ***
// configuration word store, decode and program-memory access gate
`timescale 1ns/1ps
module cwd_config_decode import cwd_pkg::*; #(
  parameter int PM_AW = 15
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [15:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic [31:0]           prdata,
  // programming controls, from pins
  input  wire logic             bulk_erase,
  input  wire logic             lv_prog_mode,
  // external program-memory port
  input  wire logic             ext_rd,
  input  wire logic             ext_wr,
  input  wire logic [13:0]      ext_rdata_raw,
  output logic                  ext_wr_ok,
  output logic [13:0]           ext_rdata,
  // cpu program-memory port
  input  wire logic             cpu_wr,
  input  wire logic [PM_AW-1:0] cpu_waddr,
  input  wire logic [13:0]      cpu_rdata_raw,
  output logic                  cpu_wr_ok,
  output logic [13:0]           cpu_rdata,
  // decoded static settings
  output logic                  clock_output_enable,
  output cwd_en_e               brownout_mode,
  output logic                  code_protect_on,
  output logic                  reset_pin_is_reset,
  output logic                  reset_pin_pullup_hw,
  output logic                  powerup_timer_on,
  output cwd_en_e               watchdog_mode,
  output cwd_osc_e              oscillator_select_field,
  output logic                  clock_input_pin_io,
  output logic                  low_voltage_program_enable,
  output logic                  low_power_brownout_on,
  output logic                  brownout_voltage_select,
  output logic                  stack_error_reset_enable,
  output logic [1:0]            self_write_protect_field,
  output logic                  settings_valid
);
  logic [13:0] configuration_word_one;
  logic [13:0] configuration_word_two;
  logic [1:0]  erase_sync;
  logic [1:0]  lvp_sync;
  logic [1:0]  samp_cnt;
  logic        erase_q;
  logic        apb_wr;
  logic        apb_rd;
  logic [13:0] next_word;
  logic        cp_latch;
  logic        words_set;

  function automatic logic prot_hit(input logic [1:0] fld, input logic [PM_AW-1:0] a);
    logic [14:0] aa;
    aa = 15'(a);
    case (fld)
      2'b10:   prot_hit = aa <= WRT_TOP_HALF;
      2'b01:   prot_hit = aa <= WRT_TOP_ONE;
      2'b00:   prot_hit = aa <= WRT_TOP_ALL;
      default: prot_hit = 1'b0;
    endcase
  endfunction : prot_hit

  // pin inputs pass two flops before use
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      erase_sync <= 2'b00;
      lvp_sync   <= 2'b00;
    end else begin
      erase_sync <= {erase_sync[0], bulk_erase};
      lvp_sync   <= {lvp_sync[0], lv_prog_mode};
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) erase_q <= 1'b0;
    else erase_q <= erase_sync[1];
  end

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;

  // programming a nonvolatile word can only clear bits, like flash cells
  always_comb begin
    next_word = configuration_word_one & pwdata[13:0];
    if (paddr == CFG2_ADDR) begin
      next_word = configuration_word_two & pwdata[13:0];
      if (lvp_sync[1]) begin
        next_word[C2_LVP] = configuration_word_two[C2_LVP];
      end
    end
  end

  // word storage; survives rst_n since it models nonvolatile cells
  always_ff @(posedge mclk) begin
    if (erase_sync[1]) begin
      configuration_word_one <= CFG_ERASED;
      configuration_word_two <= CFG_ERASED;
    end else if (apb_wr && paddr == CFG1_ADDR) begin
      configuration_word_one <= next_word | CFG1_UNIMP;
    end else if (apb_wr && paddr == CFG2_ADDR) begin
      configuration_word_two <= next_word | CFG2_UNIMP;
    end
  end

  // cells start unknown until the first erase; the unimplemented-bit and decode checks wait for it
  always_ff @(posedge mclk) begin
    if (erase_sync[1]) words_set <= 1'b1;
  end

  // apb answers in the access cycle, no wait states
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr != CFG1_ADDR && paddr != CFG2_ADDR;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite && paddr == CFG1_ADDR) prdata <= {18'h0, configuration_word_one};
      if (psel && !penable && !pwrite && paddr == CFG2_ADDR) prdata <= {18'h0, configuration_word_two};
    end
  end

  // sampling window after reset release
  always_ff @(posedge mclk) begin
    if (!rst_n) samp_cnt <= 2'b00;
    else if (samp_cnt != 2'(SAMPLE_CYC)) samp_cnt <= samp_cnt + 2'b01;
  end

  // decoded settings taken once, then frozen until next reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      settings_valid             <= 1'b0;
      clock_output_enable        <= 1'b0;
      brownout_mode              <= CWD_EN_ON;
      code_protect_on            <= 1'b0;
      reset_pin_is_reset         <= 1'b1;
      reset_pin_pullup_hw        <= 1'b1;
      powerup_timer_on           <= 1'b0;
      watchdog_mode              <= CWD_EN_ON;
      oscillator_select_field    <= CWD_OSC_EXT_HP;
      clock_input_pin_io         <= 1'b0;
      low_voltage_program_enable <= 1'b1;
      low_power_brownout_on      <= 1'b0;
      brownout_voltage_select    <= 1'b1;
      stack_error_reset_enable   <= 1'b1;
      self_write_protect_field   <= 2'b11;
    end else if (samp_cnt == 2'(SAMPLE_CYC - 1)) begin
      settings_valid             <= 1'b1;
      clock_output_enable        <= !configuration_word_one[C1_CLOCK_OUTPUT_PIN_N];
      brownout_mode              <= cwd_en_e'(configuration_word_one[C1_BOREN_LO +: 2]);
      code_protect_on            <= !configuration_word_one[C1_CP_N];
      reset_pin_is_reset         <= configuration_word_two[C2_LVP] | configuration_word_one[C1_RSTPIN];
      reset_pin_pullup_hw        <= configuration_word_two[C2_LVP] | configuration_word_one[C1_RSTPIN];
      powerup_timer_on           <= !configuration_word_one[C1_POWERUP_DELAY_TIMER_N];
      watchdog_mode              <= cwd_en_e'(configuration_word_one[C1_WDTE_LO +: 2]);
      oscillator_select_field    <= cwd_osc_e'(configuration_word_one[C1_FOSC_LO +: 2]);
      clock_input_pin_io         <= configuration_word_one[C1_FOSC_LO +: 2] == 2'b00;
      low_voltage_program_enable <= configuration_word_two[C2_LVP];
      low_power_brownout_on      <= !configuration_word_two[C2_LOW_POWER_BROWNOUT_ENABLE_N_N];
      brownout_voltage_select    <= configuration_word_two[C2_BROWNOUT_VOLTAGE_SELECT];
      stack_error_reset_enable   <= configuration_word_two[C2_STACK_ERROR_RESET_ENABLE];
      self_write_protect_field   <= configuration_word_two[C2_WRT_LO +: 2];
    end
  end

  // live protect latch: external gate must not wait for the next reset
  assign cp_latch = code_protect_on | !configuration_word_one[C1_CP_N];

  // access gates, one cycle registered
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ext_wr_ok <= 1'b0;
      ext_rdata <= 14'h0000;
      cpu_wr_ok <= 1'b0;
      cpu_rdata <= 14'h0000;
    end else begin
      ext_wr_ok <= ext_wr && !cp_latch;
      ext_rdata <= (ext_rd && !cp_latch) ? ext_rdata_raw : 14'h0000;
      cpu_wr_ok <= cpu_wr && settings_valid && !prot_hit(self_write_protect_field, cpu_waddr);
      cpu_rdata <= cpu_rdata_raw;
    end
  end

  cwd_unimp_a: assert property (@(posedge mclk) disable iff (!rst_n)
    words_set |->
    ((configuration_word_one & CFG1_UNIMP) == CFG1_UNIMP) && ((configuration_word_two & CFG2_UNIMP) == CFG2_UNIMP))
    else $error("unimplemented config bit reads zero");
  cwd_erase_a: assert property (@(posedge mclk) disable iff (!rst_n)
    erase_sync[1] |=> configuration_word_one == CFG_ERASED && configuration_word_two == CFG_ERASED)
    else $error("bulk erase did not blank words");
  // protect bit cleared, then three cycles with no erase behind it
  sequence cwd_cp_set_s;
    $fell(configuration_word_one[C1_CP_N]) ##1 !erase_q [*3];
  endsequence
  cwd_cp_sticky_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cwd_cp_set_s |-> !configuration_word_one[C1_CP_N])
    else $error("code protect cleared without erase");
  cwd_lvp_keep_a: assert property (@(posedge mclk) disable iff (!rst_n)
    lvp_sync[1] && apb_wr && paddr == CFG2_ADDR && !erase_sync[1] |=> $stable(configuration_word_two[C2_LVP]))
    else $error("lvp bit cleared in lv mode");
  cwd_ext_rd_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cp_latch |=> ext_rdata == 14'h0000) else $error("protected read leaked data");
  cwd_ext_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    ext_wr && cp_latch |=> !ext_wr_ok) else $error("protected write passed");
  cwd_cpu_rd_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n |=> cpu_rdata == $past(cpu_rdata_raw)) else $error("cpu read gated");
  cwd_cpu_wr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cpu_wr && settings_valid && self_write_protect_field == 2'b00 |=> !cpu_wr_ok)
    else $error("full protect let cpu write");
  cwd_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    settings_valid && $past(settings_valid) |-> $stable(powerup_timer_on) && $stable(watchdog_mode))
    else $error("settings changed after sampling");
  cwd_decode_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(settings_valid) && words_set |-> powerup_timer_on == !$past(configuration_word_one[C1_POWERUP_DELAY_TIMER_N])
    && reset_pin_is_reset == ($past(configuration_word_two[C2_LVP]) | $past(configuration_word_one[C1_RSTPIN])))
    else $error("decode mismatch");
endmodule : cwd_config_decode

// *** sim/test_config_word_decode_and_code_protect.sv ***
// self-checking testbench for the configuration word decoder and access gate
`timescale 1ns/1ps
module test_config_word_decode_and_code_protect import cwd_pkg::*;;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, bulk_erase, lv_prog_mode;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        ext_rd, ext_wr, ext_wr_ok, cpu_wr, cpu_wr_ok, err;
  logic [13:0] ext_rdata_raw, ext_rdata, cpu_rdata_raw, cpu_rdata;
  logic [14:0] cpu_waddr, a, top;
  logic        clock_output_enable, code_protect_on, reset_pin_is_reset, reset_pin_pullup_hw, powerup_timer_on;
  logic        clock_input_pin_io, low_voltage_program_enable, low_power_brownout_on, brownout_voltage_select;
  logic        stack_error_reset_enable, settings_valid;
  logic [1:0]  self_write_protect_field;
  cwd_en_e     brownout_mode, watchdog_mode;
  cwd_osc_e    oscillator_select_field;
  int          tests_run, fail_count, cyc;
  typedef struct {logic [13:0] c1; logic [13:0] c2; cwd_en_e bor; cwd_en_e wdt; cwd_osc_e osc;} cwd_row_s;
  cwd_row_s    r;
  // word one, word two, then the decode they should give
  cwd_row_s    rows[4] = '{'{14'h3FFF, 14'h3FFF, CWD_EN_ON, CWD_EN_ON, CWD_OSC_EXT_HP},
                           '{14'h3596, 14'h11FE, CWD_EN_RUN, CWD_EN_RUN, CWD_OSC_EXT_MP},
                           '{14'h3BED, 14'h3DFD, CWD_EN_SW, CWD_EN_SW, CWD_OSC_EXT_LP},
                           '{14'h39C4, 14'h1BFC, CWD_EN_OFF, CWD_EN_OFF, CWD_OSC_INT}};

  cwd_config_decode cwd_config_decode_inst (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .bulk_erase, .lv_prog_mode, .ext_rd, .ext_wr, .ext_rdata_raw, .ext_wr_ok, .ext_rdata,
    .cpu_wr, .cpu_waddr, .cpu_rdata_raw, .cpu_wr_ok, .cpu_rdata, .clock_output_enable, .brownout_mode,
    .code_protect_on, .reset_pin_is_reset, .reset_pin_pullup_hw, .powerup_timer_on, .watchdog_mode,
    .oscillator_select_field, .clock_input_pin_io, .low_voltage_program_enable, .low_power_brownout_on,
    .brownout_voltage_select, .stack_error_reset_enable, .self_write_protect_field, .settings_valid);

  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  task automatic summarize;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  // whole run needs well under two thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 5000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [15:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rdw(input logic [15:0] ad, input logic [13:0] exp);
    apb(1'h0, ad, 32'h0);
    check("prdata", rd, {18'h0, exp});
    check("pslverr", err, 1'h0);
  endtask : rdw

  // bulk erase pin is synchronised, so hold it across several edges
  task automatic erase;
    @(posedge mclk);
    bulk_erase <= 1'h1;
    repeat (4) @(posedge mclk);
    bulk_erase <= 1'h0;
    repeat (4) @(posedge mclk);
  endtask : erase

  task automatic reboot;
    int n;
    n = 0;
    @(posedge mclk);
    rst_n <= 1'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    while (settings_valid !== 1'h1 && n < 10) begin
      @(posedge mclk);
      n++;
    end
    #1;
    check("settings_valid", settings_valid, 1'h1);
  endtask : reboot

  task automatic pm_op(input logic er, input logic ew, input logic cw, input logic [14:0] ad, input logic [13:0] raw);
    @(posedge mclk);
    {ext_rd, ext_wr, cpu_wr} <= {er, ew, cw};
    cpu_waddr <= ad;
    ext_rdata_raw <= raw;
    cpu_rdata_raw <= raw;
    @(posedge mclk);
    #1;
  endtask : pm_op

  initial begin
    {rst_n, psel, penable, pwrite, bulk_erase, lv_prog_mode, ext_rd, ext_wr, cpu_wr} = 9'h0;
    {paddr, pwdata, ext_rdata_raw, cpu_rdata_raw, cpu_waddr} = 91'h0;
    repeat (12) @(posedge mclk);
    #1;
    check("valid_in_reset", settings_valid, 1'h0);
    check("pready_in_reset", pready, 1'h0);
    @(posedge mclk);
    rst_n <= 1'h1;
    erase();
    rdw(CFG1_ADDR, 14'h3FFF);
    rdw(CFG2_ADDR, 14'h3FFF);
    foreach (rows[i]) begin
      r = rows[i];
      erase();
      apb(1'h1, CFG1_ADDR, {18'h0, r.c1});
      apb(1'h1, CFG2_ADDR, {18'h0, r.c2});
      reboot();
      rdw(CFG1_ADDR, r.c1 | CFG1_UNIMP);
      rdw(CFG2_ADDR, r.c2 | CFG2_UNIMP);
      check("clock_output_pin_en", clock_output_enable, !r.c1[11]);
      check("bor_mode", brownout_mode, r.bor);
      check("cp_on", code_protect_on, !r.c1[7]);
      if (!r.c2[13]) check("rst_pin", reset_pin_is_reset, r.c1[6]);
      if (!r.c2[13]) check("rst_pullup", reset_pin_pullup_hw, r.c1[6]);
      check("powerup_delay_timer_on", powerup_timer_on, !r.c1[5]);
      check("wdt_mode", watchdog_mode, r.wdt);
      check("osc_sel", oscillator_select_field, r.osc);
      check("clock_input_pin_io", clock_input_pin_io, r.osc == CWD_OSC_INT);
      check("lvp_en", low_voltage_program_enable, r.c2[13]);
      check("low_power_brownout_enable_n_on", low_power_brownout_on, !r.c2[11]);
      check("brownout_voltage_select", brownout_voltage_select, r.c2[10]);
      check("stack_error_reset_enable", stack_error_reset_enable, r.c2[9]);
      check("wrt_field", self_write_protect_field, r.c2[1:0]);
      top = r.c2[1] ? WRT_TOP_HALF : (r.c2[0] ? WRT_TOP_ONE : WRT_TOP_ALL);
      // 000h, 200h and 400h straddle the 1FF and 3FF range boundaries
      for (int k = 0; k < 3; k++) begin
        a = 15'(k) << 9;
        pm_op(1'h1, 1'h1, 1'h1, a, 14'h2A50 + 14'(k));
        check("cpu_wr_ok", cpu_wr_ok, r.c2[1:0] == 2'h3 || a > top);
        check("cpu_rdata", cpu_rdata, 14'h2A50 + 14'(k));
        check("ext_rdata", ext_rdata, 14'h2A50 + 14'(k));
        check("ext_wr_ok", ext_wr_ok, 1'h1);
      end
    end
    erase();
    apb(1'h1, CFG1_ADDR, 32'h3F7F);
    apb(1'h1, CFG1_ADDR, 32'h3FFF);
    rdw(CFG1_ADDR, 14'h3F7F);
    reboot();
    check("cp_on", code_protect_on, 1'h1);
    pm_op(1'h1, 1'h1, 1'h0, 15'h0, 14'h1234);
    check("ext_rdata", ext_rdata, 14'h0);
    check("ext_wr_ok", ext_wr_ok, 1'h0);
    check("cpu_rdata", cpu_rdata, 14'h1234);
    erase();
    rdw(CFG1_ADDR, 14'h3FFF);
    reboot();
    check("cp_on", code_protect_on, 1'h0);
    @(posedge mclk);
    lv_prog_mode <= 1'h1;
    apb(1'h1, CFG2_ADDR, 32'h1FFF);
    rdw(CFG2_ADDR, 14'h3FFF);
    @(posedge mclk);
    lv_prog_mode <= 1'h0;
    repeat (3) @(posedge mclk);
    apb(1'h1, CFG2_ADDR, 32'h1FFF);
    rdw(CFG2_ADDR, 14'h1FFF);
    apb(1'h0, 16'h8006, 32'h0);
    check("pslverr", err, 1'h1);
    summarize();
  end
endmodule : test_config_word_decode_and_code_protect
